// file: inc/ccr_pkg.sv
// What this block does
// R1 - remote write block discards channel register writes
// R2 - remote target access unaffected by write block
// R3 - speed bit picks 50 ms or 1 s
// R4 - disable bit turns the watchdog off
// R5 - idle with SDA high means bus free
// R6 - idle with SDA low drives nine SCL clocks
// R7 - zero deserializer address disables its access
// R8 - lock autoloads deserializer address unless frozen
// R9 - freeze bit keeps the software written address
// R10 - software writing address should also freeze it; the code freezes only when bit 0 of the written value is set
// R11 - alias match replaced by physical target address
// R12 - zero alias disables remote target access
// R13 - watchdog restarts on any SCL or SDA edge
package ccr_pkg;
  localparam logic [7:0] ADDR_I2C_CTRL = 8'h05;
  localparam logic [7:0] ADDR_DES = 8'h06;
  localparam logic [7:0] ADDR_TGT_PHYS = 8'h07;
  localparam logic [7:0] ADDR_TGT_ALIAS = 8'h08;
  localparam logic [7:0] RESET_REG = 8'h00;
  localparam int BIT_WDOG_DIS = 0;
  localparam int BIT_WDOG_FAST = 1;
  localparam int BIT_REMOTE_WR_BLOCK = 2;
  localparam int BIT_FREEZE = 0;
  localparam longint CLK_HZ = 20000000;
  localparam longint WDOG_FAST_MS = 50;
  localparam longint WDOG_SLOW_MS = 1000;
  localparam longint WDOG_FAST_CYC_L = (WDOG_FAST_MS * CLK_HZ) / 1000;
  localparam longint WDOG_SLOW_CYC_L = (WDOG_SLOW_MS * CLK_HZ) / 1000;
  localparam int RECOVER_PULSES = 9;
  localparam int HALF_SCL_CYC = 50;

  typedef struct packed {
    logic valid;
    logic remote;
    logic write;
    logic [7:0] addr;
    logic [7:0] data;
  } ccr_reg_req_type;

  typedef struct packed {
    logic valid;
    logic [6:0] addr;
  } ccr_i2c_addr_type;
endpackage

// file: logic/ccr_bus_watchdog.sv
`timescale 1ns/10ps
module ccr_bus_watchdog #(
  parameter int FAST_CYC = 1000000,
  parameter int SLOW_CYC = 20000000
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // control
  input wire logic wdogDisable,
  input wire logic wdogFast,
  // bus lines
  input wire logic sclIn,
  input wire logic sdaIn,
  // results
  output logic busFree,
  output logic sclOut,
  output logic sclOe,
  output logic recovering
);
  typedef enum logic [1:0] {
    WD_IDLE = 2'b00,
    WD_RECOVER = 2'b01
  } ccr_wd_state_type;

  ccr_wd_state_type state, next_state;
  logic [31:0] count, next_count;
  logic [7:0] halfCnt, next_halfCnt;
  logic [4:0] edges, next_edges;
  logic busFreeR, next_busFreeR;
  logic sclPrev, sdaPrev;
  logic activity;
  logic [31:0] limit;

  assign activity = (sclIn != sclPrev) || (sdaIn != sdaPrev);
  assign limit = wdogFast ? 32'(FAST_CYC) : 32'(SLOW_CYC); // see R3

  always_comb
  begin
    next_state = state;
    next_count = count;
    next_halfCnt = halfCnt;
    next_edges = edges;
    next_busFreeR = busFreeR;
    case (state)
      WD_IDLE:
      begin
        if (wdogDisable || activity) // see R4 // see R13
        begin
          next_count = '0;
          next_busFreeR = 1'b0;
        end
        else if (count >= limit - 32'h1)
        begin
          next_count = '0;
          if (sdaIn)
            next_busFreeR = 1'b1; // see R5
          else
          begin
            next_state = WD_RECOVER; // see R6
            next_halfCnt = '0;
            next_edges = '0;
          end
        end
        else
          next_count = count + 32'h1;
      end
      WD_RECOVER:
      begin
        if (halfCnt == 8'(ccr_pkg::HALF_SCL_CYC - 1))
        begin
          next_halfCnt = '0;
          next_edges = edges + 5'h1;
          if (edges == 5'(2 * ccr_pkg::RECOVER_PULSES - 1))
            next_state = WD_IDLE; // see R6
        end
        else
          next_halfCnt = halfCnt + 8'h1;
      end
      default: next_state = WD_IDLE;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state <= WD_IDLE;
      count <= '0;
      halfCnt <= '0;
      edges <= '0;
      busFreeR <= 1'b0;
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
    end
    else
    begin
      state <= next_state;
      count <= next_count;
      halfCnt <= next_halfCnt;
      edges <= next_edges;
      busFreeR <= next_busFreeR;
      sclPrev <= sclIn;
      sdaPrev <= sdaIn;
    end
  end

  assign busFree = busFreeR;
  assign recovering = (state == WD_RECOVER);
  // low phase on even half periods; oe low means driving
  assign sclOut = 1'b0;
  assign sclOe = !(recovering && !edges[0]); // see R6
endmodule

// file: logic/ccr_control_channel.sv
`timescale 1ns/10ps
module ccr_control_channel #(
  parameter int WDOG_FAST_CYC = int'(ccr_pkg::WDOG_FAST_CYC_L),
  parameter int WDOG_SLOW_CYC = int'(ccr_pkg::WDOG_SLOW_CYC_L)
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // register access, local host or channel
  input wire ccr_pkg::ccr_reg_req_type regReq,
  output logic [7:0] regRdData,
  output logic regWrDone,
  // auto load from the channel
  input wire logic rxLock,
  input wire logic [6:0] autoDesAddr,
  // local transaction address to remap
  input wire ccr_pkg::ccr_i2c_addr_type localAddr,
  output ccr_pkg::ccr_i2c_addr_type fwdAddr,
  output logic fwdToDes,
  output logic fwdDrop,
  // i2c bus lines
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sclOut,
  output logic sclOe,
  output logic busFree,
  output logic busRecovering
);
  logic [7:0] i2cCtrl, next_i2cCtrl;
  logic [7:0] desAddr, next_desAddr;
  logic [7:0] tgtPhys, next_tgtPhys;
  logic [7:0] tgtAlias, next_tgtAlias;
  logic lockPrev;
  logic [7:0] next_regRdData;
  logic next_regWrDone;
  ccr_pkg::ccr_i2c_addr_type next_fwdAddr;
  logic next_fwdToDes, next_fwdDrop;
  logic wrOk, lockRise;

  // remote writes to own registers are dropped when blocked
  assign wrOk = regReq.valid && regReq.write
    && !(regReq.remote && i2cCtrl[ccr_pkg::BIT_REMOTE_WR_BLOCK]); // see R1
  assign lockRise = rxLock && !lockPrev;

  always_comb
  begin
    next_i2cCtrl = i2cCtrl;
    next_desAddr = desAddr;
    next_tgtPhys = tgtPhys;
    next_tgtAlias = tgtAlias;
    next_regWrDone = wrOk;
    next_regRdData = regRdData;
    if (lockRise && !desAddr[ccr_pkg::BIT_FREEZE]) // see R8 // see R9
      next_desAddr = {autoDesAddr, desAddr[ccr_pkg::BIT_FREEZE]};
    if (wrOk)
    begin
      case (regReq.addr)
        ccr_pkg::ADDR_I2C_CTRL: next_i2cCtrl = {5'h00, regReq.data[2:0]};
        ccr_pkg::ADDR_DES: next_desAddr = regReq.data; // see R9
        ccr_pkg::ADDR_TGT_PHYS: next_tgtPhys = {regReq.data[7:1], 1'b0};
        ccr_pkg::ADDR_TGT_ALIAS: next_tgtAlias = {regReq.data[7:1], 1'b0};
        default: next_i2cCtrl = i2cCtrl;
      endcase
    end
    if (regReq.valid && !regReq.write)
    begin
      case (regReq.addr)
        ccr_pkg::ADDR_I2C_CTRL: next_regRdData = i2cCtrl;
        ccr_pkg::ADDR_DES: next_regRdData = desAddr;
        ccr_pkg::ADDR_TGT_PHYS: next_regRdData = tgtPhys;
        ccr_pkg::ADDR_TGT_ALIAS: next_regRdData = tgtAlias;
        default: next_regRdData = 8'h00;
      endcase
    end
  end

  // address remap; remote target access ignores the write block
  always_comb
  begin
    next_fwdAddr = '0;
    next_fwdToDes = 1'b0;
    next_fwdDrop = 1'b0;
    if (localAddr.valid) // see R2
    begin
      if (tgtAlias[7:1] != 7'h00 && localAddr.addr == tgtAlias[7:1]) // see R12
      begin
        next_fwdAddr = '{valid: 1'b1, addr: tgtPhys[7:1]}; // see R11
        next_fwdToDes = 1'b1;
      end
      else if (desAddr[7:1] != 7'h00 && localAddr.addr == desAddr[7:1]) // see R7
      begin
        next_fwdAddr = '{valid: 1'b1, addr: desAddr[7:1]};
        next_fwdToDes = 1'b1;
      end
      else
        next_fwdDrop = 1'b1;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      i2cCtrl <= ccr_pkg::RESET_REG;
      desAddr <= ccr_pkg::RESET_REG;
      tgtPhys <= ccr_pkg::RESET_REG;
      tgtAlias <= ccr_pkg::RESET_REG;
      lockPrev <= 1'b0;
      regRdData <= 8'h00;
      regWrDone <= 1'b0;
      fwdAddr <= '0;
      fwdToDes <= 1'b0;
      fwdDrop <= 1'b0;
    end
    else
    begin
      i2cCtrl <= next_i2cCtrl;
      desAddr <= next_desAddr;
      tgtPhys <= next_tgtPhys;
      tgtAlias <= next_tgtAlias;
      lockPrev <= rxLock;
      regRdData <= next_regRdData;
      regWrDone <= next_regWrDone;
      fwdAddr <= next_fwdAddr;
      fwdToDes <= next_fwdToDes;
      fwdDrop <= next_fwdDrop;
    end
  end

  ccr_bus_watchdog #(
    .FAST_CYC(WDOG_FAST_CYC),
    .SLOW_CYC(WDOG_SLOW_CYC)
  ) watchdog (
    .mclk(mclk),
    .rst(rst),
    .wdogDisable(i2cCtrl[ccr_pkg::BIT_WDOG_DIS]), // see R4
    .wdogFast(i2cCtrl[ccr_pkg::BIT_WDOG_FAST]), // see R3
    .sclIn(sclIn),
    .sdaIn(sdaIn),
    .busFree(busFree),
    .sclOut(sclOut),
    .sclOe(sclOe),
    .recovering(busRecovering)
  );

  AST_REMOTE_BLOCK: assert property (@(posedge mclk) disable iff (rst) // see R1
    regReq.valid && regReq.write && regReq.remote && i2cCtrl[2] && regReq.addr == ccr_pkg::ADDR_TGT_ALIAS
    |=> $stable(tgtAlias)) else $error("blocked remote write changed a register");
  AST_LOCAL_WRITE: assert property (@(posedge mclk) disable iff (rst) // see R1
    regReq.valid && regReq.write && !regReq.remote && regReq.addr == ccr_pkg::ADDR_TGT_ALIAS
    |=> tgtAlias[7:1] == $past(regReq.data[7:1])) else $error("local write lost");
  AST_REMAP_NOT_BLOCKED: assert property (@(posedge mclk) disable iff (rst) // see R2
    localAddr.valid && tgtAlias[7:1] != 7'h00 && localAddr.addr == tgtAlias[7:1]
    && !(regReq.valid && regReq.write) |=> fwdToDes) else $error("remote target access blocked");
  AST_REMAP_ADDR: assert property (@(posedge mclk) disable iff (rst) // see R11
    localAddr.valid && tgtAlias[7:1] != 7'h00 && localAddr.addr == tgtAlias[7:1]
    |=> fwdAddr.addr == $past(tgtPhys[7:1])) else $error("alias not remapped");
  AST_ZERO_ALIAS: assert property (@(posedge mclk) disable iff (rst) // see R12
    localAddr.valid && tgtAlias[7:1] == 7'h00 && desAddr[7:1] == 7'h00 |=> fwdDrop && !fwdToDes)
    else $error("zero address not disabled");
  AST_ZERO_DES: assert property (@(posedge mclk) disable iff (rst) // see R7
    localAddr.valid && desAddr[7:1] == 7'h00 && localAddr.addr != tgtAlias[7:1] |=> !fwdToDes)
    else $error("zero deserializer address not disabled");
  AST_AUTOLOAD: assert property (@(posedge mclk) disable iff (rst) // see R8
    lockRise && !desAddr[0] && !(regReq.valid && regReq.write) |=> desAddr[7:1] == $past(autoDesAddr))
    else $error("autoload missed");
  AST_FREEZE: assert property (@(posedge mclk) disable iff (rst) // see R9
    lockRise && desAddr[0] && !(regReq.valid && regReq.write) |=> $stable(desAddr))
    else $error("frozen address overwritten");
  AST_WDOG_OFF: assert property (@(posedge mclk) disable iff (rst) // see R4
    i2cCtrl[0] && !busRecovering |=> !busRecovering && !busFree) else $error("watchdog acted while off");
  AST_ACTIVITY: assert property (@(posedge mclk) disable iff (rst) // see R13
    !busRecovering && (sdaIn != $past(sdaIn)) |=> !busFree) else $error("activity did not restart watchdog");
  AST_NINE_CLOCKS: assert property (@(posedge mclk) disable iff (rst) // see R6
    $rose(busRecovering) |-> busRecovering [*8] ##[1:900] !busRecovering) else $error("recovery length wrong");
  AST_FREE_SDA: assert property (@(posedge mclk) disable iff (rst) // see R5
    $rose(busFree) |-> $past(sdaIn)) else $error("bus free while SDA low");
  CVR_REMAP: cover property (@(posedge mclk) disable iff (rst) fwdToDes && fwdAddr.addr == tgtPhys[7:1]);
  CVR_RECOVER: cover property (@(posedge mclk) disable iff (rst) $fell(busRecovering));
  CVR_FREE: cover property (@(posedge mclk) disable iff (rst) $rose(busFree));
  CVR_AUTOLOAD: cover property (@(posedge mclk) disable iff (rst) lockRise && !desAddr[0]);
  CVR_BLOCKED: cover property (@(posedge mclk) disable iff (rst) !wrOk && regReq.valid && regReq.write);

  // cycle count of one recovery, for the length check
  logic [9:0] recCycles, next_recCycles;

  always_comb
  begin
    next_recCycles = busRecovering ? recCycles + 10'h001 : 10'h000;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      recCycles <= 10'h000;
    else
      recCycles <= next_recCycles;
  end

  AST_BLOCKED_NO_DONE: assert property (@(posedge mclk) disable iff (rst) // see R1
    regReq.valid && regReq.write && regReq.remote && i2cCtrl[ccr_pkg::BIT_REMOTE_WR_BLOCK] |=> !regWrDone)
    else $error("blocked remote write acknowledged");
  AST_REMOTE_WR_OPEN: assert property (@(posedge mclk) disable iff (rst) // see R1
    regReq.valid && regReq.write && !i2cCtrl[ccr_pkg::BIT_REMOTE_WR_BLOCK] |=> regWrDone)
    else $error("unblocked write not acknowledged");
  AST_DES_READ: assert property (@(posedge mclk) disable iff (rst) // see R9
    regReq.valid && !regReq.write && regReq.addr == ccr_pkg::ADDR_DES |=> regRdData == $past(desAddr))
    else $error("deserializer address read wrong");
  AST_RESERVED_ZERO: assert property (@(posedge mclk) disable iff (rst) // see R11
    !tgtPhys[0] && !tgtAlias[0] && i2cCtrl[7:3] == 5'h00) else $error("reserved bit set");
  AST_RECOVER_LENGTH: assert property (@(posedge mclk) disable iff (rst) // see R6
    $fell(busRecovering) |-> recCycles == 10'(2 * ccr_pkg::RECOVER_PULSES * ccr_pkg::HALF_SCL_CYC))
    else $error("recovery length wrong");
endmodule

// file: verification/ccr_control_channel_test.sv
`timescale 1ns/10ps
module ccr_control_channel_test;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  ccr_pkg::ccr_reg_req_type regReq = '0;
  ccr_pkg::ccr_reg_req_type tReq = '0;
  ccr_pkg::ccr_i2c_addr_type localAddr = '0;
  ccr_pkg::ccr_i2c_addr_type fwdAddr;
  logic [7:0] regRdData;
  logic [6:0] autoDesAddr = 7'h00;
  logic [6:0] al, ph, ds, ds2;
  logic rxLock = 1'b0;
  logic hangSda = 1'b0;
  logic blipSda = 1'b0;
  logic tLoc = 1'b0;
  logic sclPrev;
  logic regWrDone, fwdToDes, fwdDrop, sclLine, sdaLine, sclOut, sclOe, busFree, busRecovering;
  logic [8:0] expQ[$];
  logic [8:0] expNote;
  logic [31:0] rnd = 32'hCA82;
  int error_cnt = 0;
  int compares = 0;
  int falls = 0;

  always #25 mclk = ~mclk;

  ccr_control_channel #(.WDOG_FAST_CYC(20), .WDOG_SLOW_CYC(40)) u_ccr_control_channel (
    .mclk(mclk), .rst(rst), .regReq(regReq), .regRdData(regRdData), .regWrDone(regWrDone),
    .rxLock(rxLock), .autoDesAddr(autoDesAddr), .localAddr(localAddr), .fwdAddr(fwdAddr),
    .fwdToDes(fwdToDes), .fwdDrop(fwdDrop), .sclIn(sclLine), .sdaIn(sdaLine), .sclOut(sclOut),
    .sclOe(sclOe), .busFree(busFree), .busRecovering(busRecovering));

  ccr_i2c_partner u_ccr_i2c_partner (.sclOut(sclOut), .sclOe(sclOe), .hangSda(hangSda),
    .blipSda(blipSda), .sclLine(sclLine), .sdaLine(sdaLine));

  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] r;
    r = v ^ (v << 13);
    r = r ^ (r >> 17);
    return r ^ (r << 5);
  endfunction

  task automatic check(input string name, input logic [8:0] got, input logic [8:0] exp);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic acc(input logic rm, input logic wr, input logic [7:0] a, input logic [7:0] d, input logic [8:0] e);
    @(posedge mclk);
    regReq <= '{1'b1, rm, wr, a, d};
    expQ.push_back(e);
    @(posedge mclk);
    regReq <= '0;
  endtask

  task automatic remap(input logic [6:0] a, input logic [8:0] e);
    @(posedge mclk);
    localAddr <= '{1'b1, a};
    expQ.push_back(e);
    @(posedge mclk);
    localAddr <= '0;
  endtask

  task automatic lock(input logic [6:0] a);
    @(posedge mclk);
    autoDesAddr <= a;
    rxLock <= 1'b0;
    @(posedge mclk);
    rxLock <= 1'b1;
    cyc(2);
  endtask

  task automatic blip();
    @(posedge mclk);
    blipSda <= 1'b1;
    @(posedge mclk);
    blipSda <= 1'b0;
  endtask

  // result watcher
  always @(posedge mclk)
  begin
    tReq <= regReq;
    tLoc <= localAddr.valid;
  end

  always @(posedge mclk)
  begin
    #1;
    if (tReq.valid || tLoc)
    begin
      if (expQ.size() == 0)
        check("queue", 9'h1FF, 9'h000);
      else
      begin
        expNote = expQ.pop_front();
        if (tLoc)
        begin
          check("remap", {fwdToDes, fwdDrop, fwdDrop ? 7'h00 : fwdAddr.addr}, expNote);
          check("remap valid", {8'h00, fwdAddr.valid}, {8'h00, expNote[8]});
        end
        else
          check("register", tReq.write ? {8'h00, regWrDone} : {1'b0, regRdData}, expNote);
      end
    end
  end

  initial
  begin
    #500000;
    error_cnt++;
    finish_test();
  end

  initial
  begin
    rnd = xs(rnd);
    al = {rnd[5:0], 1'b1};
    rnd = xs(rnd);
    ph = rnd[6:0];
    rnd = xs(rnd);
    ds = {1'b1, rnd[4:0], 1'b0};
    ds2 = ds ^ 7'h04;
    cyc(4);
    rst <= 1'b0;
    for (int i = 5; i < 10; i++)
      acc(1'b0, 1'b0, (i == 9) ? 8'h3C : 8'(i), 8'h00, 9'h000);
    remap(al, 9'h080);
    acc(1'b0, 1'b1, ccr_pkg::ADDR_TGT_ALIAS, {al, 1'b1}, 9'h001);
    acc(1'b0, 1'b1, ccr_pkg::ADDR_TGT_PHYS, {ph, 1'b1}, 9'h001);
    acc(1'b0, 1'b0, ccr_pkg::ADDR_TGT_ALIAS, 8'h00, {1'b0, al, 1'b0});
    acc(1'b0, 1'b0, ccr_pkg::ADDR_TGT_PHYS, 8'h00, {1'b0, ph, 1'b0});
    acc(1'b1, 1'b1, ccr_pkg::ADDR_TGT_PHYS, {ph, 1'b0}, 9'h001);
    remap(al, {2'b10, ph});
    lock(ds);
    acc(1'b0, 1'b0, ccr_pkg::ADDR_DES, 8'h00, {1'b0, ds, 1'b0});
    remap(ds, {2'b10, ds});
    remap(ds ^ 7'h02, 9'h080);
    acc(1'b0, 1'b1, ccr_pkg::ADDR_I2C_CTRL, 8'hFC, 9'h001);
    acc(1'b0, 1'b0, ccr_pkg::ADDR_I2C_CTRL, 8'h00, 9'h004);
    acc(1'b1, 1'b1, ccr_pkg::ADDR_TGT_ALIAS, 8'h00, 9'h000);
    acc(1'b0, 1'b0, ccr_pkg::ADDR_TGT_ALIAS, 8'h00, {1'b0, al, 1'b0});
    remap(al, {2'b10, ph});
    acc(1'b0, 1'b1, ccr_pkg::ADDR_DES, {ds2, 1'b1}, 9'h001);
    lock(ds);
    acc(1'b0, 1'b0, ccr_pkg::ADDR_DES, 8'h00, {1'b0, ds2, 1'b1});
    acc(1'b0, 1'b1, ccr_pkg::ADDR_DES, 8'h00, 9'h001);
    remap(ds2, 9'h080);
    $display("test registers and remap done");
    acc(1'b0, 1'b1, ccr_pkg::ADDR_I2C_CTRL, 8'h01, 9'h001);
    cyc(100);
    #1 check("busFree off", {8'h00, busFree}, 9'h000);
    acc(1'b0, 1'b1, ccr_pkg::ADDR_I2C_CTRL, 8'h00, 9'h001);
    blip();
    cyc(30);
    #1 check("busFree slow early", {8'h00, busFree}, 9'h000);
    cyc(25);
    #1 check("busFree slow", {8'h00, busFree}, 9'h001);
    blip();
    cyc(2);
    #1 check("busFree restart", {8'h00, busFree}, 9'h000);
    acc(1'b0, 1'b1, ccr_pkg::ADDR_I2C_CTRL, 8'h02, 9'h001);
    blip();
    cyc(12);
    #1 check("busFree fast early", {8'h00, busFree}, 9'h000);
    cyc(15);
    #1 check("busFree fast", {8'h00, busFree}, 9'h001);
    $display("test watchdog free done");
    @(posedge mclk);
    hangSda <= 1'b1;
    sclPrev = 1'b1;
    repeat (930)
    begin
      @(posedge mclk);
      #1;
      if (sclPrev && !sclLine)
        falls++;
      sclPrev = sclLine;
    end
    check("recovery clocks", 9'(falls), 9'h009);
    check("recovering", {8'h00, busRecovering}, 9'h000);
    @(posedge mclk);
    hangSda <= 1'b0;
    $display("test watchdog recovery done");
    finish_test();
  end
endmodule

// file: verification/ccr_i2c_partner.sv
`timescale 1ns/10ps
module ccr_i2c_partner (
  // block side
  input wire logic sclOut,
  input wire logic sclOe,
  // far side behaviour
  input wire logic hangSda,
  input wire logic blipSda,
  // pulled-up lines
  output logic sclLine,
  output logic sdaLine
);
  assign sclLine = sclOe ? 1'b1 : sclOut;
  assign sdaLine = ~(hangSda | blipSda);
endmodule
